// ---- hdl/port_latch_map.svh ----
// Register offsets, reset values and field positions of the port block
`ifndef PORT_LATCH_MAP_SVH
`define PORT_LATCH_MAP_SVH
`define PORT_ZERO_OFS 8'h80
`define PORT_ONE_OFS 8'h90
`define PORT_TWO_OFS 8'ha0
`define PORT_THREE_OFS 8'hb0
`define PORT_CTRL_OFS 8'hc0
`define PORT_PIN_BASE_OFS 8'hd0
`define PORT_LATCH_RESET 8'hff
`define PORT_CTRL_RESET 8'h00
`define CTRL_EXT_MEM_BIT 0
`define CTRL_PULSE_A_BIT 1
`define CTRL_PULSE_B_BIT 2
`define CTRL_PULSE_CLK_BIT 3
`define PULSE_A_POS 5
`define PULSE_B_POS 6
`define PULSE_CLK_POS 7
`define LANE0_LO 0
`define LANE0_HI 7
`endif

// ---- hdl/port_latch_pkg.sv ----
// Types shared by the port block
package port_latch_pkg;
	typedef enum logic [2:0] {
		bus_idle = 3'b001,
		bus_ack = 3'b010,
		bus_done = 3'b100
	} bus_state_e;
	typedef logic [7:0] byte_t;
endpackage

// ---- hdl/pin_sync_if.sv ----
// Carrier between the top and the pin synchroniser
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if #(parameter int WIDTH = 32);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] synced;
	modport top (output raw, input synced);
	modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Pin levels
	pin_sync_if.sync pins
);
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] stage_two;
	// Refused while the design is built, not at run time
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_sync width must be positive");
	end
	always_ff @(posedge clock) begin
		if (srst) begin
			stage_one <= '0;
			stage_two <= '0;
		end else begin
			stage_one <= pins.raw;
			stage_two <= stage_one;
		end
	end
	assign pins.synced = stage_two;
endmodule
`default_nettype wire

// ---- hdl/port_pad.sv ----
// Output stage of one eight-bit port: pull-up style or open-drain style
`timescale 1ns/100ps
`default_nettype none
module port_pad #(
	parameter bit OPEN_DRAIN = 1'b0
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Drive request
	input wire logic [7:0] level,
	input wire logic [7:0] push,
	// Pin drive
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	output logic [7:0] pull_up
);
	// Registered so every top output comes straight from a flip-flop
	always_ff @(posedge clock) begin
		if (srst) begin
			pin_out <= '0;
			pin_oe <= '0;
			pull_up <= '0;
		end else begin
			pin_out <= level & push;
			// A zero always sinks; a one drives only when push-pull is requested
			pin_oe <= ~level | push;
			pull_up <= OPEN_DRAIN ? 8'h00 : (level & ~push);
		end
	end
endmodule
`default_nettype wire

// ---- hdl/quad_parallel_port_latches.sv ----
// Four eight-bit parallel ports with bit latches behind a Wishbone slave
`timescale 1ns/100ps
`default_nettype none
`include "port_latch_map.svh"
module quad_parallel_port_latches (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// External memory bus
	input wire logic ext_mem_active,
	input wire logic [7:0] ext_addr_data,
	input wire logic [15:0] ext_addr_upper,
	input wire logic ext_write_strobe,
	input wire logic ext_read_strobe,
	// On-chip peripheral outputs
	input wire logic pulse_out_a,
	input wire logic pulse_out_b,
	input wire logic spi_sclock_out,
	input wire logic spi_mosi_out,
	input wire logic spi_miso_out,
	input wire logic [2:0] spi_drive_en,
	input wire logic serial_transmit_out,
	// Peripheral inputs taken from pins
	output logic spi_sclock_in,
	output logic spi_mosi_in,
	output logic spi_miso_in,
	output logic spi_select_timer_two_clock,
	output logic timer_two_ext_control,
	output logic pulse_gen_ext_clock,
	output logic serial_receive,
	output logic ext_irq_a,
	output logic ext_irq_b,
	output logic timer_zero_input,
	output logic timer_one_input,
	// Port pins
	input wire logic [7:0] port_zero_pin_in,
	output logic [7:0] port_zero_pin_out,
	output logic [7:0] port_zero_pin_oe,
	input wire logic [7:0] port_one_pin_in,
	output logic [7:0] port_one_analog_sel,
	input wire logic [7:0] port_two_pin_in,
	output logic [7:0] port_two_pin_out,
	output logic [7:0] port_two_pin_oe,
	output logic [7:0] port_two_pull_up,
	input wire logic [7:0] port_three_pin_in,
	output logic [7:0] port_three_pin_out,
	output logic [7:0] port_three_pin_oe,
	output logic [7:0] port_three_pull_up
);
	port_latch_pkg::byte_t port_zero_latch;
	port_latch_pkg::byte_t port_one_latch;
	port_latch_pkg::byte_t port_two_latch;
	port_latch_pkg::byte_t port_three_latch;
	port_latch_pkg::byte_t port_ctrl;
	port_latch_pkg::bus_state_e bus_state;
	port_latch_pkg::byte_t next_read;
	port_latch_pkg::byte_t lane;
	logic [7:0] pin_zero_s, pin_one_s, pin_two_s, pin_three_s;
	logic bus_req;
	logic bus_write;
	logic [7:0] two_level, two_push, three_level, three_push, zero_level, zero_push;
	logic [7:0] ext_lo;

	pin_sync_if #(.WIDTH(32)) pins ();

	// Pin levels are asynchronous; synchronised before reads or peripherals see them
	assign pins.raw = {port_three_pin_in, port_two_pin_in, port_one_pin_in, port_zero_pin_in};
	pin_sync #(.WIDTH(32)) u_sync (
		.clock(clock),
		.srst(srst),
		.pins(pins)
	);
	assign pin_zero_s = pins.synced[7:0];
	assign pin_one_s = pins.synced[15:8];
	assign pin_two_s = pins.synced[23:16];
	assign pin_three_s = pins.synced[31:24];

	assign bus_req = wb_cyc_i && wb_stb_i && (bus_state == port_latch_pkg::bus_idle);
	assign bus_write = bus_req && wb_we_i && wb_sel_i[0];
	assign lane = wb_dat_i[`LANE0_HI:`LANE0_LO];

	// One wait state, then ack for one cycle, then a gap while the master releases
	always_ff @(posedge clock) begin
		if (srst) begin
			bus_state <= port_latch_pkg::bus_idle;
		end else begin
			case (bus_state)
				port_latch_pkg::bus_idle: begin
					if (wb_cyc_i && wb_stb_i) begin
						bus_state <= port_latch_pkg::bus_ack;
					end
				end
				port_latch_pkg::bus_ack: begin
					bus_state <= port_latch_pkg::bus_done;
				end
				port_latch_pkg::bus_done: begin
					bus_state <= port_latch_pkg::bus_idle;
				end
				default: begin
					bus_state <= port_latch_pkg::bus_idle;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_req;
		end
	end

	// Latch offsets read the latch, used by modify-write sequences; pin offsets read pins
	always_comb begin
		next_read = 8'h00;
		case (wb_adr_i)
			`PORT_ZERO_OFS: next_read = port_zero_latch;
			`PORT_ONE_OFS: next_read = port_one_latch;
			`PORT_TWO_OFS: next_read = port_two_latch;
			`PORT_THREE_OFS: next_read = port_three_latch;
			`PORT_CTRL_OFS: next_read = port_ctrl;
			`PORT_PIN_BASE_OFS: next_read = pin_zero_s;
			`PORT_PIN_BASE_OFS + 8'h04: next_read = pin_one_s;
			`PORT_PIN_BASE_OFS + 8'h08: next_read = pin_two_s;
			`PORT_PIN_BASE_OFS + 8'h0c: next_read = pin_three_s;
			default: next_read = 8'h00;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && !wb_we_i) begin
			wb_dat_o <= {24'h00_0000, next_read};
		end
	end

	// Bit writes arrive as whole bytes; software merges into the latch value it read
	always_ff @(posedge clock) begin
		if (srst) begin
			port_zero_latch <= `PORT_LATCH_RESET;
		end else if (ext_mem_active) begin
			port_zero_latch <= `PORT_LATCH_RESET;
		end else if (bus_write && wb_adr_i == `PORT_ZERO_OFS) begin
			port_zero_latch <= lane;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			port_one_latch <= `PORT_LATCH_RESET;
		end else if (bus_write && wb_adr_i == `PORT_ONE_OFS) begin
			port_one_latch <= lane;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			port_two_latch <= `PORT_LATCH_RESET;
		end else if (bus_write && wb_adr_i == `PORT_TWO_OFS) begin
			port_two_latch <= lane;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			port_three_latch <= `PORT_LATCH_RESET;
		end else if (bus_write && wb_adr_i == `PORT_THREE_OFS) begin
			port_three_latch <= lane;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			port_ctrl <= `PORT_CTRL_RESET;
		end else if (bus_write && wb_adr_i == `PORT_CTRL_OFS) begin
			port_ctrl <= lane;
		end
	end

	// Port zero: latch value open-drain, or push-pull address/data in external mode
	assign ext_lo = ext_addr_data;
	always_comb begin
		if (ext_mem_active) begin
			zero_level = ext_lo;
			zero_push = 8'hff;
		end else begin
			zero_level = port_zero_latch;
			zero_push = 8'h00;
		end
	end

	port_pad #(.OPEN_DRAIN(1'b1)) u_pad_zero (
		.clock(clock),
		.srst(srst),
		.level(zero_level),
		.push(zero_push),
		.pin_out(port_zero_pin_out),
		.pin_oe(port_zero_pin_oe),
		.pull_up()
	);

	// Port two: address byte, pulse overrides, SPI drive, else latch with pull-up
	always_comb begin
		two_level = port_two_latch;
		two_push = 8'h00;
		if (ext_mem_active) begin
			two_level = ext_addr_upper[15:8];
			two_push = 8'hff;
		end else begin
			two_level[2:0] = port_two_latch[2:0] &
				(~spi_drive_en | {spi_miso_out, spi_mosi_out, spi_sclock_out});
			if (port_ctrl[`CTRL_PULSE_A_BIT]) begin
				two_level[`PULSE_A_POS] = pulse_out_a;
			end
			if (port_ctrl[`CTRL_PULSE_B_BIT]) begin
				two_level[`PULSE_B_POS] = pulse_out_b;
			end
		end
	end

	port_pad #(.OPEN_DRAIN(1'b0)) u_pad_two (
		.clock(clock),
		.srst(srst),
		.level(two_level),
		.push(two_push),
		.pin_out(port_two_pin_out),
		.pin_oe(port_two_pin_oe),
		.pull_up(port_two_pull_up)
	);

	// Port three: alternate outputs are gated by the latch so a zero latch holds low
	always_comb begin
		three_level = port_three_latch;
		three_push = 8'h00;
		three_level[1] = port_three_latch[1] & serial_transmit_out;
		three_level[6] = port_three_latch[6] & ~(ext_mem_active & ext_write_strobe);
		three_level[7] = port_three_latch[7] & ~(ext_mem_active & ext_read_strobe);
	end

	port_pad #(.OPEN_DRAIN(1'b0)) u_pad_three (
		.clock(clock),
		.srst(srst),
		.level(three_level),
		.push(three_push),
		.pin_out(port_three_pin_out),
		.pin_oe(port_three_pin_oe),
		.pull_up(port_three_pull_up)
	);

	// Peripheral inputs from synchronised pins; port three inputs need latch one
	always_ff @(posedge clock) begin
		if (srst) begin
			spi_sclock_in <= 1'b0;
			spi_mosi_in <= 1'b0;
			spi_miso_in <= 1'b0;
			spi_select_timer_two_clock <= 1'b0;
			timer_two_ext_control <= 1'b0;
			pulse_gen_ext_clock <= 1'b0;
			serial_receive <= 1'b0;
			ext_irq_a <= 1'b0;
			ext_irq_b <= 1'b0;
			timer_zero_input <= 1'b0;
			timer_one_input <= 1'b0;
		end else begin
			spi_sclock_in <= pin_two_s[0];
			spi_mosi_in <= pin_two_s[1];
			spi_miso_in <= pin_two_s[2];
			spi_select_timer_two_clock <= pin_two_s[3];
			timer_two_ext_control <= pin_two_s[4];
			pulse_gen_ext_clock <= port_ctrl[`CTRL_PULSE_CLK_BIT] & pin_two_s[`PULSE_CLK_POS];
			serial_receive <= pin_three_s[0] & port_three_latch[0];
			ext_irq_a <= pin_three_s[2] & port_three_latch[2];
			ext_irq_b <= pin_three_s[3] & port_three_latch[3];
			timer_zero_input <= pin_three_s[4] & port_three_latch[4];
			timer_one_input <= pin_three_s[5] & port_three_latch[5];
		end
	end

	// Port one never drives; the latch only chooses analog or digital input
	always_ff @(posedge clock) begin
		if (srst) begin
			port_one_analog_sel <= `PORT_LATCH_RESET;
		end else begin
			port_one_analog_sel <= port_one_latch;
		end
	end
endmodule
`default_nettype wire

// ---- tb/port_latch_asserts.sv ----
// Assertions on the bus answer and pin behaviour of the port block
`timescale 1ns/100ps
`default_nettype none
module port_latch_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// External memory and peripherals
	input wire logic ext_mem_active,
	input wire logic [7:0] ext_addr_data,
	input wire logic [15:0] ext_addr_upper,
	input wire logic ext_write_strobe,
	input wire logic ext_read_strobe,
	input wire logic [2:0] spi_drive_en,
	input wire logic timer_two_ext_control,
	// Pins
	input wire logic [7:0] port_zero_pin_out,
	input wire logic [7:0] port_zero_pin_oe,
	input wire logic [7:0] port_one_analog_sel,
	input wire logic [7:0] port_two_pin_in,
	input wire logic [7:0] port_two_pin_out,
	input wire logic [7:0] port_three_pin_out,
	input wire logic [7:0] port_three_pin_oe
);
	logic [2:0] since_rst;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// Synchroniser history is only valid once it has refilled after reset
	always_ff @(posedge clock) begin
		if (srst) begin
			since_rst <= 3'h0;
		end else if (since_rst != 3'h4) begin
			since_rst <= since_rst + 3'h1;
		end
	end
	ack_timing_a: assert property (
		$rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer mistimed");
	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	p0_float_a: assert property ((!ext_mem_active)[*3]
		|-> (port_zero_pin_out & port_zero_pin_oe) == 8'h00)
		else $error("port zero drives high in general mode");
	p0_push_a: assert property (
		(ext_mem_active && $stable(ext_addr_data))[*3]
		|-> port_zero_pin_oe == 8'hff && port_zero_pin_out == ext_addr_data)
		else $error("port zero not pushing address data");
	p2_addr_a: assert property (
		(ext_mem_active && spi_drive_en == 3'h0 && $stable(ext_addr_upper))[*3]
		|-> port_two_pin_out == ext_addr_upper[15:8])
		else $error("port two not showing upper address");
	p3_strobe_a: assert property (
		(ext_mem_active && ext_write_strobe && ext_read_strobe)[*3]
		|-> port_three_pin_oe[7:6] == 2'b11 && port_three_pin_out[7:6] == 2'b00)
		else $error("memory strobes not driven low");
	sync_delay_a: assert property (since_rst == 3'h4
		|-> timer_two_ext_control == $past(port_two_pin_in[4], 3))
		else $error("pin input delay wrong");
	analog_rst_a: assert property ($fell(srst) |-> port_one_analog_sel == 8'hff)
		else $error("port one not analog after reset");
endmodule
`default_nettype wire

// ---- tb/pin_world.sv ----
// Pin-side model: pad drive, pull-up, external source or drifting float
`timescale 1ns/100ps
`default_nettype none
module pin_world (
	// Clock
	input wire logic clock,
	// Pad drive
	input wire logic [7:0] out,
	input wire logic [7:0] oe,
	input wire logic [7:0] pull,
	// External source
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	// Level seen by the port
	output logic [7:0] pin
);
	logic [7:0] last = 8'h00;
	// An undriven, unpulled line drifts so a stale level never reads back
	assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pull)
		| (~oe & ~ext_en & ~pull & ~last);
	always_ff @(posedge clock) begin
		last <= pin;
	end
endmodule
`default_nettype wire

// ---- tb/test_quad_parallel_port_latches.sv ----
// Testbench for the four-port latch block
`timescale 1ns/100ps
`default_nettype none
`include "port_latch_map.svh"
module test_quad_parallel_port_latches;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic ext_mem_active = 1'b0, ext_write_strobe = 1'b0, ext_read_strobe = 1'b0;
	logic [7:0] ext_addr_data = 8'h00, q;
	logic [15:0] ext_addr_upper = 16'h0000;
	logic pulse_out_a = 1'b0, pulse_out_b = 1'b0, serial_transmit_out = 1'b1;
	logic spi_sclock_out = 1'b1, spi_mosi_out = 1'b1, spi_miso_out = 1'b1;
	logic [2:0] spi_drive_en = 3'h0;
	logic spi_sclock_in, spi_mosi_in, spi_miso_in, spi_select_timer_two_clock;
	logic timer_two_ext_control, pulse_gen_ext_clock, serial_receive, ext_irq_a;
	logic ext_irq_b, timer_zero_input, timer_one_input;
	logic [7:0] port_zero_pin_in, port_zero_pin_out, port_zero_pin_oe, port_one_analog_sel;
	logic [7:0] port_two_pin_in, port_two_pin_out, port_two_pin_oe, port_two_pull_up;
	logic [7:0] port_three_pin_in, port_three_pin_out, port_three_pin_oe, port_three_pull_up;
	logic [7:0] port_one_pin_in = 8'h3c;
	logic [7:0] three_ext_val = 8'h00, three_ext_en = 8'h00;
	int bad_count = 0;
	int checks = 0;
	quad_parallel_port_latches quad_parallel_port_latches_i (.*);
	pin_world pins_zero (.clock(clock), .out(port_zero_pin_out), .oe(port_zero_pin_oe),
		.pull(8'h00), .ext_val(8'ha5), .ext_en(8'hff), .pin(port_zero_pin_in));
	pin_world pins_two (.clock(clock), .out(port_two_pin_out), .oe(port_two_pin_oe),
		.pull(port_two_pull_up), .ext_val(8'h00), .ext_en(8'h00), .pin(port_two_pin_in));
	pin_world pins_three (.clock(clock), .out(port_three_pin_out), .oe(port_three_pin_oe),
		.pull(port_three_pull_up), .ext_val(three_ext_val), .ext_en(three_ext_en),
		.pin(port_three_pin_in));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d};
		for (n = 0; n < 16; n++) begin
			@(posedge clock);
			if (wb_ack_o === 1'b1) break;
		end
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n == 16) begin
			bad_count++;
			finish_test();
		end
	endtask
	initial begin
		forever #2.5 clock = ~clock;
	end
	initial begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, `PORT_ZERO_OFS + 8'(i * 16), 8'h00);
			check(q, `PORT_LATCH_RESET);
		end
		check(port_one_analog_sel, 8'hff);
		bus(1'b1, `PORT_ONE_OFS, 8'h5a);
		bus(1'b0, `PORT_ONE_OFS, 8'h00);
		check(q, 8'h5a);
		check(port_one_analog_sel, 8'h5a);
		// A write with its byte lane off is acked but must leave the latch alone
		wb_sel_i <= 4'h0;
		bus(1'b1, `PORT_ONE_OFS, 8'h00);
		wb_sel_i <= 4'h1;
		bus(1'b0, `PORT_ONE_OFS, 8'h00);
		check(q, 8'h5a);
		bus(1'b1, `PORT_ZERO_OFS, 8'h0f);
		repeat (4) @(posedge clock);
		bus(1'b0, `PORT_PIN_BASE_OFS, 8'h00);
		check(q, 8'h05);
		bus(1'b0, `PORT_ZERO_OFS, 8'h00);
		check(q, 8'h0f);
		bus(1'b1, `PORT_THREE_OFS, 8'hf0);
		bus(1'b0, `PORT_THREE_OFS, 8'h00);
		bus(1'b1, `PORT_THREE_OFS, q | 8'h01);
		// Pad register plus two synchroniser stages before the pin reads back
		repeat (4) @(posedge clock);
		bus(1'b0, `PORT_PIN_BASE_OFS + 8'h0c, 8'h00);
		check(q, 8'hf1);
		check({serial_receive, ext_irq_a, port_three_pull_up[5:0]}, 8'hb1);
		three_ext_en <= 8'h30;
		three_ext_val <= 8'h20;
		repeat (5) @(posedge clock);
		check({5'h00, ext_irq_b, timer_one_input, timer_zero_input}, 8'h02);
		three_ext_en <= 8'h00;
		bus(1'b1, `PORT_THREE_OFS, 8'hf3);
		serial_transmit_out <= 1'b0;
		repeat (4) @(posedge clock);
		bus(1'b0, `PORT_PIN_BASE_OFS + 8'h0c, 8'h00);
		check(q, 8'hf1);
		bus(1'b1, `PORT_TWO_OFS, 8'h00);
		bus(1'b1, `PORT_CTRL_OFS, 8'h06);
		for (int k = 0; k < 2; k++) begin
			pulse_out_a <= (k == 0);
			pulse_out_b <= (k == 1);
			port_one_pin_in <= k ? 8'hc3 : 8'h3c;
			repeat (5) @(posedge clock);
			bus(1'b0, `PORT_PIN_BASE_OFS + 8'h08, 8'h00);
			check(q, k ? 8'h40 : 8'h20);
			bus(1'b0, `PORT_PIN_BASE_OFS + 8'h04, 8'h00);
			check(q, k ? 8'hc3 : 8'h3c);
		end
		ext_mem_active <= 1'b1;
		ext_addr_data <= 8'h3c;
		ext_addr_upper <= 16'h9600;
		ext_write_strobe <= 1'b1;
		ext_read_strobe <= 1'b1;
		repeat (5) @(posedge clock);
		check(port_zero_pin_oe, 8'hff);
		check({3'h0, port_two_pin_out[4:0]}, 8'h16);
		ext_mem_active <= 1'b0;
		ext_write_strobe <= 1'b0;
		ext_read_strobe <= 1'b0;
		bus(1'b0, `PORT_ZERO_OFS, 8'h00);
		check(q, 8'hff);
		bus(1'b1, 8'h44, 8'h77);
		bus(1'b0, 8'h44, 8'h00);
		check(q, 8'h00);
		// SPI clock driven low by its peripheral; the other SPI lines follow the latch
		bus(1'b1, `PORT_TWO_OFS, 8'h87);
		spi_drive_en <= 3'h1;
		spi_sclock_out <= 1'b0;
		bus(1'b1, `PORT_CTRL_OFS, 8'h08);
		repeat (5) @(posedge clock);
		check({7'h00, pulse_gen_ext_clock}, 8'h01);
		check({5'h00, spi_miso_in, spi_mosi_in, spi_sclock_in}, 8'h06);
		check({6'h00, spi_select_timer_two_clock, timer_two_ext_control}, 8'h00);
		check(port_two_pin_oe, 8'h79);
		bus(1'b0, `PORT_PIN_BASE_OFS + 8'h08, 8'h00);
		check(q, 8'h86);
		// Reset again in mid-run: port one must fall back to analog inputs
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		bus(1'b0, `PORT_ONE_OFS, 8'h00);
		check(q, 8'hff);
		check(port_one_analog_sel, 8'hff);
		finish_test();
	end
endmodule
bind quad_parallel_port_latches port_latch_checker port_latch_checker_i (.*);
`default_nettype wire
